// ===== sse_defines.svh
// constants for the search engine sram write command block
`ifndef SSE_DEFINES_SVH
`define SSE_DEFINES_SVH

// command bus and data/query bus layout
`define SSE_CMD_W        9
`define SSE_DQ_W         68
`define SSE_CMD_OP       1:0
`define SSE_CMD_BURST    2
`define SSE_CMD_HIADDR   8:6
`define SSE_DQ_TARGET    20:19
`define SSE_DQ_CHIPSEL   25:21
`define SSE_DQ_LOADDR    18:0
`define SSE_OP_WRITE     2'h1
`define SSE_TGT_SRAM     2'h2

// sram address
`define SSE_ADDR_W       22

// table size codes and write latency from cycle 1b
`define SSE_TSZ_ONE      2'h0
`define SSE_TSZ_EIGHT    2'h1
`define SSE_TSZ_FULL     2'h2
`define SSE_LAT_ONE      3'h4
`define SSE_LAT_EIGHT    3'h5
`define SSE_LAT_FULL     3'h6
`define SSE_TAP_BASE     3'h3
`define SSE_DLY_DEPTH    4

// register map
`define SSE_REG_AW       4
`define SSE_REG_CFG      4'h0
`define SSE_REG_STATUS   4'h4
`define SSE_REG_LAST     4'h8
`define SSE_CFG_TSZ      1:0
`define SSE_CFG_HOST_LATENCY     4:2
`define SSE_CFG_CSN      9:5
`define SSE_CFG_W        10
`define SSE_CFG_RST      10'h000
`define SSE_CNT_W        16

`endif

// ===== sse_pkg.sv
// types shared by the sram write command block
`default_nettype none
package sse_pkg;
   typedef enum logic [1:0] {
      SSE_IDLE = 2'h0,
      SSE_CYCB = 2'h1,
      SSE_PAD2 = 2'h2,
      SSE_PAD3 = 2'h3
   } sse_state_t;
endpackage
`default_nettype wire

// ===== sse_launch_if.sv
// carrier between the command decoder and the latency delay line
`timescale 1ns/1ns
`default_nettype none
`include "sse_defines.svh"
interface sse_launch_if;
   logic                    in_valid;
   logic [`SSE_ADDR_W-1:0]  in_addr;
   logic [1:0]              tap;
   logic                    out_valid;
   logic [`SSE_ADDR_W-1:0]  out_addr;
   modport ctrl (output in_valid, output in_addr, output tap,
                 input out_valid, input out_addr);
   modport line (input in_valid, input in_addr, input tap,
                 output out_valid, output out_addr);
endinterface
`default_nettype wire

// ===== sse_delay_line.sv
// small storage of pending sram writes, read out through a register
`timescale 1ns/1ns
`default_nettype none
`include "sse_defines.svh"
module sse_delay_line
(
   input  wire logic   clk_i,
   input  wire logic   rst_b_i,
   sse_launch_if.line  lnk
);
   logic [`SSE_DLY_DEPTH-1:0]  valid_q;
   logic [`SSE_ADDR_W-1:0]     addr_q [`SSE_DLY_DEPTH];
   logic                       out_valid_q;
   logic [`SSE_ADDR_W-1:0]     out_addr_q;

   assign lnk.out_valid = out_valid_q;
   assign lnk.out_addr  = out_addr_q;

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         valid_q     <= '0;
         out_valid_q <= 1'b0;
      end
      else
      begin
         valid_q     <= {valid_q[`SSE_DLY_DEPTH-2:0], lnk.in_valid};
         out_valid_q <= valid_q[lnk.tap];
      end
   end

   // address words need no reset, their valid bit guards them
   always_ff @(posedge clk_i)
   begin
      addr_q[0] <= lnk.in_addr;
      for (int i = 1; i < `SSE_DLY_DEPTH; i++)
         addr_q[i] <= addr_q[i-1];
      out_addr_q <= addr_q[lnk.tap];
   end
endmodule
`default_nettype wire

// ===== sse_sram_write.sv
// sram write command decoder and external sram write cycle generator
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "sse_defines.svh"
module sse_sram_write
(
   input  wire logic                     SYS_CLK_I,
   input  wire logic                     RST_B_I,
   input  wire logic                     COMMAND_VALID_I,
   input  wire logic [`SSE_CMD_W-1:0]    CMD_I,
   input  wire logic [`SSE_DQ_W-1:0]     DQ_I,
   input  wire logic [`SSE_REG_AW-1:0]   REG_ADDR_I,
   input  wire logic [31:0]              REG_WDATA_I,
   input  wire logic                     REG_WR_I,
   input  wire logic                     REG_RD_I,
   output var  logic [31:0]              REG_RDATA_O,
   output var  logic [`SSE_ADDR_W-1:0]   SRAM_ADDRESS_O,
   output var  logic                     SRAM_CE_B_O,
   output var  logic                     SRAM_WE_B_O,
   output var  logic                     SRAM_ALE_B_O
);
   sse_pkg::sse_state_t        state_q;
   sse_pkg::sse_state_t        state_d;
   logic [`SSE_CFG_W-1:0]      cfg_q;
   logic [`SSE_CNT_W-1:0]      wr_cnt_q;
   logic [`SSE_ADDR_W-1:0]     last_addr_q;
   logic [2:0]                 hi_addr_q;
   sse_launch_if               lnk ();

   // latency to the sram bus for a table size code
   function automatic logic [2:0] lat_of(input logic [1:0] tsz);
      case (tsz)
         `SSE_TSZ_ONE:   lat_of = `SSE_LAT_ONE;
         `SSE_TSZ_EIGHT: lat_of = `SSE_LAT_EIGHT;
         default:        lat_of = `SSE_LAT_FULL;
      endcase
   endfunction

   wire [1:0] tsz_w     = cfg_q[`SSE_CFG_TSZ];
   wire       op_wr_w   = COMMAND_VALID_I && (CMD_I[`SSE_CMD_OP] == `SSE_OP_WRITE);
   wire       start_w   = op_wr_w && !CMD_I[`SSE_CMD_BURST];
   wire       tgt_w     = DQ_I[`SSE_DQ_TARGET] == `SSE_TGT_SRAM;
   wire       sel_w     = DQ_I[`SSE_DQ_CHIPSEL] == cfg_q[`SSE_CFG_CSN];
   wire       in_1a_w   = (state_q == sse_pkg::SSE_IDLE) && start_w;
   wire       in_1b_w   = state_q == sse_pkg::SSE_CYCB;
   wire       accept_w  = in_1b_w && start_w && tgt_w && sel_w;
   wire [`SSE_ADDR_W-1:0] addr_w = {hi_addr_q, DQ_I[`SSE_DQ_LOADDR]};
   wire [2:0] tap_w     = lat_of(tsz_w) - `SSE_TAP_BASE;
   wire       hit_cfg_w = REG_ADDR_I == `SSE_REG_CFG;
   wire       hit_sts_w = REG_ADDR_I == `SSE_REG_STATUS;
   wire       hit_lst_w = REG_ADDR_I == `SSE_REG_LAST;
   wire [31:0] rd_mux_w =
      hit_cfg_w ? {22'h00_0000, cfg_q} :
      hit_sts_w ? {14'h0000, state_q, wr_cnt_q} :
      hit_lst_w ? {10'h000, last_addr_q} : 32'h0000_0000;

   assign lnk.in_valid = accept_w;
   assign lnk.in_addr  = addr_w;
   assign lnk.tap      = tap_w[1:0];

   sse_delay_line u_dly
   (
      .clk_i   (SYS_CLK_I),
      .rst_b_i (RST_B_I),
      .lnk     (lnk)
   );

   // 1a, 1b, then two padding cycles with the data bus ignored
   always_comb
   begin
      case (state_q)
         sse_pkg::SSE_IDLE: state_d = start_w ? sse_pkg::SSE_CYCB : state_q;
         sse_pkg::SSE_CYCB: state_d = sse_pkg::SSE_PAD2;
         sse_pkg::SSE_PAD2: state_d = sse_pkg::SSE_PAD3;
         sse_pkg::SSE_PAD3: state_d = sse_pkg::SSE_IDLE;
         default:           state_d = sse_pkg::SSE_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (!RST_B_I)
         state_q <= sse_pkg::SSE_IDLE;
      else
         state_q <= state_d;
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (!RST_B_I)
         hi_addr_q <= 3'h0;
      else if (in_1a_w)
         hi_addr_q <= CMD_I[`SSE_CMD_HIADDR];
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (!RST_B_I)
      begin
         cfg_q       <= `SSE_CFG_RST;
         wr_cnt_q    <= '0;
         last_addr_q <= '0;
         REG_RDATA_O <= 32'h0000_0000;
      end
      else
      begin
         if (REG_WR_I && hit_cfg_w)
            cfg_q <= REG_WDATA_I[`SSE_CFG_W-1:0];
         if (lnk.out_valid)
         begin
            wr_cnt_q    <= wr_cnt_q + 16'h0001;
            last_addr_q <= lnk.out_addr;
         end
         REG_RDATA_O <= REG_RD_I ? rd_mux_w : 32'h0000_0000;
      end
   end

   // one cycle of chip enable, write enable and address latch
   always_ff @(posedge SYS_CLK_I)
   begin
      if (!RST_B_I)
      begin
         SRAM_ADDRESS_O <= '0;
         SRAM_CE_B_O    <= 1'b1;
         SRAM_WE_B_O    <= 1'b1;
         SRAM_ALE_B_O   <= 1'b1;
      end
      else
      begin
         if (lnk.out_valid)
            SRAM_ADDRESS_O <= lnk.out_addr;
         SRAM_CE_B_O  <= !lnk.out_valid;
         SRAM_WE_B_O  <= !lnk.out_valid;
         SRAM_ALE_B_O <= !lnk.out_valid;
      end
   end

   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_B_I);

   lat_one_a: assert property (
      accept_w && tsz_w == `SSE_TSZ_ONE && $stable(tsz_w)
      |-> ##4 (!SRAM_CE_B_O && SRAM_ADDRESS_O == $past(addr_w, 4)))
      else $error("write cycle missing at latency four");
   lat_eight_a: assert property (
      accept_w && tsz_w == `SSE_TSZ_EIGHT
      |-> ##5 (!SRAM_WE_B_O && SRAM_ADDRESS_O == $past(addr_w, 5)))
      else $error("write cycle missing at latency five");
   lat_full_a: assert property (
      accept_w && tsz_w == `SSE_TSZ_FULL
      |-> ##6 (!SRAM_ALE_B_O && SRAM_ADDRESS_O == $past(addr_w, 6)))
      else $error("write cycle missing at latency six");
   one_strobe_a: assert property (
      !SRAM_CE_B_O && $stable(tsz_w) |=> SRAM_CE_B_O)
      else $error("write strobe longer than one cycle");
   sel_match_a: assert property (
      !SRAM_CE_B_O && tsz_w == `SSE_TSZ_ONE && $past(tsz_w, 4) == tsz_w
      |-> $past(DQ_I[`SSE_DQ_CHIPSEL], 4) == cfg_q[`SSE_CFG_CSN])
      else $error("write by a device that was not selected");
   target_a: assert property (
      !SRAM_CE_B_O && tsz_w == `SSE_TSZ_ONE && $past(tsz_w, 4) == tsz_w
      |-> $past(DQ_I[`SSE_DQ_TARGET], 4) == `SSE_TGT_SRAM)
      else $error("write without sram target pattern");
   hi_addr_a: assert property (
      accept_w |-> addr_w[21:19] == $past(CMD_I[`SSE_CMD_HIADDR], 1))
      else $error("upper address not taken from cycle 1a");
   pad_seq_a: assert property (
      in_1b_w |=> state_q == sse_pkg::SSE_PAD2 && !accept_w
      ##1 state_q == sse_pkg::SSE_PAD3 && !accept_w)
      else $error("padding cycles not ignored");
   back_to_back_a: assert property (
      state_q == sse_pkg::SSE_PAD3 ##1 start_w
      |=> state_q == sse_pkg::SSE_CYCB)
      else $error("command after cycle 3 not taken");

   cov_one_c:   cover property (accept_w && tsz_w == `SSE_TSZ_ONE);
   cov_eight_c: cover property (accept_w && tsz_w == `SSE_TSZ_EIGHT);
   cov_full_c:  cover property (accept_w && tsz_w == `SSE_TSZ_FULL);
   cov_b2b_c:   cover property (accept_w ##4 accept_w);
endmodule
`default_nettype wire

// ===== sse_host_model.sv
// host model driving the command and data/query buses
`timescale 1ns/1ns
`default_nettype none
`include "sse_defines.svh"
module sse_host_model
(
   input  wire logic                  clk_i,
   input  wire logic [31:0]           cyc_i,
   output var  logic                  valid_o,
   output var  logic [`SSE_CMD_W-1:0] cmd_o,
   output var  logic [`SSE_DQ_W-1:0]  dq_o
);
   initial
   begin
      valid_o = 1'b0;
      cmd_o   = '0;
      dq_o    = '0;
   end
   // 1a, 1b, then two pads with the bus still driven
   task automatic send(input logic [4:0] csn, input logic [1:0] tgt,
                       input logic [21:0] adr, output logic [31:0] t1b);
      @(posedge clk_i);
      valid_o <= 1'b1;
      cmd_o   <= {adr[21:19], 4'h0, `SSE_OP_WRITE};
      dq_o    <= {42'h2a5_5a5a_5a5a, csn, tgt, adr[18:0]};
      @(posedge clk_i);
      t1b = cyc_i;
      repeat (2) @(posedge clk_i);
   endtask
   // bus stays driven but changes when idle
   task automatic idle();
      @(posedge clk_i);
      valid_o <= 1'b0;
      cmd_o   <= ~cmd_o;
      dq_o    <= ~dq_o;
   endtask
endmodule
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the sram write command block
`timescale 1ns/1ns
`default_nettype none
`include "sse_defines.svh"
module testbench;
   logic                    clk;
   logic                    rst_b;
   logic [31:0]             cyc;
   logic                    cv;
   logic [`SSE_CMD_W-1:0]   cmd;
   logic [`SSE_DQ_W-1:0]    dq;
   logic [3:0]              ra;
   logic [31:0]             wd;
   logic                    wr;
   logic                    rd;
   logic [31:0]             rdat;
   logic [21:0]             sa;
   logic                    ce_b;
   logic                    we_b;
   logic                    ale_b;
   int                      bad_count;
   int                      tests_run;
   int                      nwr;
   logic [31:0]             qc[$];
   logic [21:0]             qa[$];
   sse_sram_write dut (.SYS_CLK_I(clk), .RST_B_I(rst_b),
      .COMMAND_VALID_I(cv), .CMD_I(cmd), .DQ_I(dq), .REG_ADDR_I(ra),
      .REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat),
      .SRAM_ADDRESS_O(sa), .SRAM_CE_B_O(ce_b), .SRAM_WE_B_O(we_b),
      .SRAM_ALE_B_O(ale_b));
   sse_host_model host (.clk_i(clk), .cyc_i(cyc), .valid_o(cv),
      .cmd_o(cmd), .dq_o(dq));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 32'h0000_0001;
   always @(negedge clk)
   begin
      if (rst_b && !(ce_b && we_b && ale_b))
      begin
         check({ce_b, we_b, ale_b}, 3'h0);
         qc.push_back(cyc);
         qa.push_back(sa);
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      ra <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      rd <= 1'b1;
      ra <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdat;
   endtask
   task automatic do_write(input logic [4:0] csn, input logic [1:0] tgt,
                           input logic [21:0] a, input int lat);
      logic [31:0] t;
      qc.delete();
      qa.delete();
      host.send(csn, tgt, a, t);
      host.idle();
      repeat (10) @(posedge clk);
      check(qc.size(), (lat > 0) ? 1 : 0);
      if (lat > 0 && qc.size() > 0)
      begin
         check(qc[0], t + lat + 1);
         check(qa[0], a);
         nwr++;
      end
   endtask
   task automatic t_reset();
      logic [31:0] d;
      check({ce_b, we_b, ale_b}, 3'h7);
      for (int a = 0; a < 16; a += 4)
      begin
         reg_rd(a[3:0], d);
         check(d, 32'h0000_0000);
      end
   endtask
   task automatic t_latency();
      logic [31:0] d;
      int lat [4] = '{`SSE_LAT_ONE, `SSE_LAT_EIGHT, `SSE_LAT_FULL,
                      `SSE_LAT_FULL};
      for (int i = 0; i < 4; i++)
      begin
         reg_wr(`SSE_REG_CFG, {22'h0, 5'h1f, 3'h5, i[1:0]});
         reg_rd(`SSE_REG_CFG, d);
         check(d, {22'h0, 5'h1f, 3'h5, i[1:0]});
         do_write(5'h1f, 2'h2, {i[1:0], 20'hc_a5a5}, lat[i]);
      end
   endtask
   task automatic t_refuse();
      reg_wr(`SSE_REG_CFG, 32'h0000_00a0);
      do_write(5'h04, 2'h2, 22'h00_1234, 0);
      do_write(5'h05, 2'h1, 22'h00_1234, 0);
      do_write(5'h05, 2'h3, 22'h00_1234, 0);
      do_write(5'h05, 2'h2, 22'h2a_aaaa, `SSE_LAT_ONE);
   endtask
   task automatic t_b2b();
      logic [31:0] t1;
      logic [31:0] t2;
      qc.delete();
      qa.delete();
      host.send(5'h05, 2'h2, 22'h15_5555, t1);
      host.send(5'h05, 2'h2, 22'h0a_aaaa, t2);
      host.idle();
      repeat (12) @(posedge clk);
      check(t2 - t1, 32'h0000_0004);
      check(qc.size(), 2);
      if (qc.size() == 2)
      begin
         check(qc[1], t2 + `SSE_LAT_ONE + 1);
         check(qa[0], 22'h15_5555);
         check(qa[1], 22'h0a_aaaa);
      end
      nwr += 2;
   endtask
   task automatic t_status();
      logic [31:0] d;
      reg_wr(`SSE_REG_STATUS, 32'hffff_ffff);
      reg_wr(`SSE_REG_LAST, 32'h0000_0000);
      reg_rd(`SSE_REG_STATUS, d);
      check(d[17:0], nwr);
      reg_rd(`SSE_REG_LAST, d);
      check(d, 32'h000a_aaaa);
      @(negedge clk);
      check(rdat, 32'h0000_0000);
   endtask
   task automatic t_rst_hold();
      logic [31:0] d;
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (64) @(posedge clk);
      rst_b <= 1'b1;
      check({ce_b, we_b, ale_b}, 3'h7);
      reg_rd(`SSE_REG_CFG, d);
      check(d, 32'h0000_0000);
      reg_rd(`SSE_REG_STATUS, d);
      check(d, 32'h0000_0000);
      do_write(5'h00, 2'h2, 22'h3f_ffff, `SSE_LAT_ONE);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      #100000;
      bad_count++;
      final_report();
   end
   initial
   begin
      {rst_b, ra, wd, wr, rd, bad_count, tests_run, nwr} = '0;
      cyc = '0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_latency();
      t_refuse();
      t_b2b();
      t_status();
      t_rst_hold();
      final_report();
   end
endmodule
`default_nettype wire
